/* logic/bcc_pkg.sv */
// package: constants and carrier types for the battery charge control block
package bcc_pkg;

	// clock and time base
	localparam int unsigned CLK_HZ           = 50_000_000;
	localparam int unsigned SAMPLE_MS        = 125;
	localparam int unsigned SAMPLE_CYCLES    = CLK_HZ / 1000 * SAMPLE_MS;
	localparam int unsigned BCAST_PERIOD_S   = 10;
	localparam int unsigned BCAST_TICKS      = BCAST_PERIOD_S * 1000 / SAMPLE_MS;

	// temperature arithmetic, 0.1 degree units
	localparam logic [15:0] FAST_HYST_DECI   = 16'h001e;  // 3.0 degrees
	localparam logic [15:0] TEMP_CAP_DECI    = 16'h007f;  // 12.7 degrees

	// pack configuration field
	localparam int unsigned BCAST_DIS_POS    = 2;

	// status alarm fields
	localparam logic [15:0] HOST_ALARM_MASK  = 16'hff00;
	localparam logic [15:0] CHGR_ALARM_MASK  = 16'hf000;

	// message kinds
	typedef enum logic [1:0] {
		BCC_MSG_CHARGE_REQ,
		BCC_MSG_ALARM_HOST,
		BCC_MSG_ALARM_CHARGER
	} bcc_msg_type;

	// flash-held settings
	typedef struct packed {
		logic [15:0] charging_voltage;
		logic [15:0] overvoltage_margin;
		logic [15:0] fast_current;
		logic [15:0] maint_current;
		logic [15:0] precharge_current;
		logic [15:0] precharge_voltage;
		logic [15:0] precharge_temp_threshold;
		logic [15:0] inhibit_temp_low;
		logic [15:0] suspend_temp_high;
		logic [15:0] suspend_temp_high_reset;
		logic [15:0] suspend_temp_low;
		logic [15:0] cell_ov_limit;
		logic [15:0] cell_ov_reset;
		logic [15:0] oc_threshold;
		logic [7:0]  oc_time;
		logic [15:0] fault_clear_current_level;
		logic [7:0]  fault_clear_dwell_time;
		logic [15:0] max_charge_time;
		logic [15:0] pulse_von;
		logic [15:0] pulse_voff;
		logic [15:0] pulse_vmax;
		logic [7:0]  pulse_min_off;
		logic [7:0]  pulse_max_on;
		logic [7:0]  pack_config;
		logic        fixed_pack_bit;
		logic        overtemp_fet_enable_bit;
		logic        pulse_mode;
	} bcc_flash_constant_type;

	// measured pack state
	typedef struct packed {
		logic [15:0] pack_voltage;
		logic [15:0] max_cell;
		logic [15:0] min_cell;
		logic [15:0] temperature;
		logic [15:0] charge_current;
		logic [15:0] avg_current;
		logic        charging;
		logic        discharging;
		logic        pack_removed;
		logic        end_discharge_level_zero;
		logic        fast_terminated;
		logic [15:0] battery_status;
	} bcc_meas_type;

	// outgoing message
	typedef struct packed {
		bcc_msg_type kind;
		logic [15:0] current;
		logic [15:0] voltage;
		logic [15:0] status;
	} bcc_msg_type_s_type;

	// fault flags
	typedef struct packed {
		logic overcurrent;
		logic overtemp;
		logic undertemp;
		logic timeout;
		logic overvoltage;
	} bcc_fault_type;

endpackage

/* logic/bcc_pulse.sv */
// pulse-charge on/off control of the charge switch
`timescale 1ns/10ps
module bcc_pulse
	import bcc_pkg::*;
(
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	// sample strobe and inputs
	input  wire logic        sample_in,
	input  wire logic        active_in,
	input  wire logic [15:0] max_cell_in,
	input  wire logic [15:0] von_in,
	input  wire logic [15:0] voff_in,
	input  wire logic [15:0] vmax_in,
	input  wire logic [7:0]  min_off_in,
	input  wire logic [7:0]  max_on_in,
	// switch request
	output logic             fet_on_out
);

	logic       fet_on,    next_fet_on;
	logic [7:0] off_count, next_off_count;
	logic [7:0] on_count,  next_on_count;
	logic       counting,  next_counting;

	// pulse decisions taken once per sample, counts in sample units
	always_comb begin
		next_fet_on    = fet_on;
		next_off_count = off_count;
		next_on_count  = on_count;
		next_counting  = counting;
		if (!active_in) begin
			next_fet_on    = 1'b1;
			next_off_count = 8'h00;
			next_counting  = 1'b0;
		end else if (sample_in) begin
			if (fet_on) begin
				if (max_cell_in > vmax_in) begin
					next_fet_on    = 1'b0;
					next_off_count = 8'h00;
					next_counting  = 1'b0;
				end else if (counting && on_count == 8'h00) begin
					next_fet_on    = 1'b0;
					next_off_count = 8'h00;
					next_counting  = 1'b0;
				end else if (counting) begin
					next_on_count = on_count - 8'h01;
				end else if (max_cell_in > voff_in) begin
					next_counting = 1'b1;
					next_on_count = max_on_in;
				end
			end else begin
				if (max_cell_in < von_in && off_count >= min_off_in)
					next_fet_on = 1'b1;
				else if (off_count != 8'hff)
					next_off_count = off_count + 8'h01;
			end
		end
	end

	// pulse state registers
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			fet_on    <= 1'b1;
			off_count <= 8'h00;
			on_count  <= 8'h00;
			counting  <= 1'b0;
		end else begin
			fet_on    <= next_fet_on;
			off_count <= next_off_count;
			on_count  <= next_on_count;
			counting  <= next_counting;
		end
	end

	assign fet_on_out = fet_on;

endmodule

/* logic/bcc_top.sv */
// charge control policy: requests, alarms, faults and pulse charge
`timescale 1ns/10ps
module bcc_top
	import bcc_pkg::*;
#(
	parameter int unsigned SAMPLE_CNT = SAMPLE_CYCLES
)
(
	// clock and reset
	input  wire logic                   clock_in,
	input  wire logic                   rst_in,
	// settings and measurements
	input  wire bcc_flash_constant_type flash_constant_in,
	input  wire bcc_meas_type           meas_in,
	// message port
	output logic                        msg_valid_out,
	input  wire logic                   msg_ready_in,
	output bcc_msg_type_s_type          msg_out,
	// switches and status
	output logic                        charge_fet_out,
	output logic                        discharge_fet_out,
	output bcc_fault_type               fault_out,
	output logic [15:0]                 charging_current_out,
	output logic [15:0]                 charging_voltage_out
);

	////////////////////////////////////////////////////////////////////////////////
	// time base

	logic [31:0] div_count, next_div_count;
	logic        tick;

	// one enable pulse per 125 ms
	always_comb begin
		next_div_count = div_count + 32'h1;
		if (div_count >= SAMPLE_CNT - 1)
			next_div_count = 32'h0;
	end
	assign tick = (div_count >= SAMPLE_CNT - 1);

	////////////////////////////////////////////////////////////////////////////////
	// fault detection

	bcc_flash_constant_type fc;
	bcc_meas_type           m;
	bcc_fault_type          fault, next_fault;
	logic [7:0]             oc_count, next_oc_count;
	logic [7:0]             clr_count, next_clr_count;
	logic [15:0]            chg_time, next_chg_time;
	logic [16:0]            ov_level;
	logic [15:0]            low_clear;
	logic                   fixed_clear, any_fault;

	assign fc = flash_constant_in;
	assign m  = meas_in;
	assign ov_level  = {1'b0, fc.charging_voltage} + {1'b0, fc.overvoltage_margin};
	assign low_clear = (fc.suspend_temp_low > TEMP_CAP_DECI) ? TEMP_CAP_DECI
		: fc.suspend_temp_low;
	assign fixed_clear = fc.fixed_pack_bit
		&& (m.discharging || clr_count >= fc.fault_clear_dwell_time);
	assign any_fault = |fault;

	// fault set and clear, set wins over clear
	always_comb begin
		next_fault     = fault;
		next_oc_count  = oc_count;
		next_clr_count = clr_count;
		next_chg_time  = chg_time;
		if (tick) begin
			if (m.charge_current > fc.oc_threshold) begin
				if (oc_count != 8'hff)
					next_oc_count = oc_count + 8'h01;
			end else
				next_oc_count = 8'h00;
			if (m.avg_current < fc.fault_clear_current_level) begin
				if (clr_count != 8'hff)
					next_clr_count = clr_count + 8'h01;
			end else
				next_clr_count = 8'h00;
			if (m.charging && chg_time != 16'hffff)
				next_chg_time = chg_time + 16'h0001;
		end
		if (m.discharging || m.pack_removed)
			next_chg_time = 16'h0000;
		// overcurrent
		if (m.pack_removed || fixed_clear)
			next_fault.overcurrent = 1'b0;
		if (oc_count > fc.oc_time)
			next_fault.overcurrent = 1'b1;
		// overvoltage, release needs levels back down
		if ((m.pack_removed || fixed_clear) && {1'b0, m.pack_voltage} < ov_level
			&& m.max_cell < fc.cell_ov_reset)
			next_fault.overvoltage = 1'b0;
		if (m.max_cell > fc.cell_ov_limit || {1'b0, m.pack_voltage} > ov_level)
			next_fault.overvoltage = 1'b1;
		// overtemperature
		if (m.temperature <= fc.suspend_temp_high_reset || m.pack_removed)
			next_fault.overtemp = 1'b0;
		if (m.charging && m.temperature > fc.suspend_temp_high)
			next_fault.overtemp = 1'b1;
		// undertemperature
		if (m.temperature > low_clear || m.pack_removed)
			next_fault.undertemp = 1'b0;
		if (m.charging && (m.temperature < fc.suspend_temp_low
			|| m.temperature < fc.inhibit_temp_low))
			next_fault.undertemp = 1'b1;
		// charge timeout
		if (m.discharging || m.pack_removed)
			next_fault.timeout = 1'b0;
		if (m.charging && chg_time >= fc.max_charge_time)
			next_fault.timeout = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// charging current selection

	logic        pre_volt, next_pre_volt;
	logic        term_seen, next_term_seen;
	logic [15:0] pc_temp, next_current, next_voltage;
	logic [15:0] cur_req, volt_req;
	logic        pre_temp, fast_ok;

	assign pc_temp  = (fc.precharge_temp_threshold > TEMP_CAP_DECI) ? TEMP_CAP_DECI
		: fc.precharge_temp_threshold;
	assign pre_temp = m.temperature >= fc.inhibit_temp_low
		&& m.temperature < pc_temp + FAST_HYST_DECI;
	assign fast_ok  = m.temperature >= pc_temp + FAST_HYST_DECI;

	// precharge latch and current priority
	always_comb begin
		next_pre_volt  = pre_volt;
		next_term_seen = term_seen | m.fast_terminated;
		if (m.min_cell < fc.precharge_voltage || m.end_discharge_level_zero)
			next_pre_volt = 1'b1;
		else if (m.min_cell > fc.precharge_voltage)
			next_pre_volt = 1'b0;
		if (m.pack_removed || m.discharging)
			next_term_seen = 1'b0;
		next_voltage = any_fault ? 16'h0000 : fc.charging_voltage;
		if (any_fault)
			next_current = 16'h0000;
		else if (pre_volt || pre_temp)
			next_current = fc.precharge_current;
		else if (m.fast_terminated)
			next_current = 16'h0000;
		else if (term_seen)
			next_current = fc.maint_current;
		else if (fast_ok)
			next_current = fc.fast_current;
		else
			next_current = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// broadcast scheduler

	typedef enum logic [1:0] {
		BC_IDLE,
		BC_REQ,
		BC_HOST,
		BC_CHGR
	} bcc_bc_state_type;

	bcc_bc_state_type   bc_state, next_bc_state;
	logic [7:0]         bc_ticks, next_bc_ticks;
	bcc_msg_type_s_type msg, next_msg;
	logic               bc_dis, host_alarm, chgr_alarm;

	assign bc_dis     = fc.pack_config[BCAST_DIS_POS];
	assign host_alarm = |(m.battery_status & HOST_ALARM_MASK);
	assign chgr_alarm = |(m.battery_status & CHGR_ALARM_MASK);

	// a burst every 10 s: request, then alarms while set
	always_comb begin
		next_bc_state = bc_state;
		next_bc_ticks = bc_ticks;
		next_msg      = msg;
		if (tick)
			next_bc_ticks = (bc_ticks >= 8'(BCAST_TICKS - 1)) ? 8'h00 : bc_ticks + 8'h01;
		unique case (bc_state)
			BC_IDLE: begin
				if (tick && bc_ticks >= 8'(BCAST_TICKS - 1) && !bc_dis) begin
					next_bc_state = BC_REQ;
					next_msg      = '{BCC_MSG_CHARGE_REQ, cur_req, volt_req, 16'h0000};
				end
			end
			BC_REQ: begin
				if (msg_ready_in) begin
					next_msg = '{BCC_MSG_ALARM_HOST, 16'h0000, 16'h0000, m.battery_status};
					next_bc_state = (host_alarm && !bc_dis) ? BC_HOST : BC_IDLE;
				end
			end
			BC_HOST: begin
				if (msg_ready_in) begin
					next_msg = '{BCC_MSG_ALARM_CHARGER, 16'h0000, 16'h0000,
						m.battery_status};
					next_bc_state = (chgr_alarm && !bc_dis) ? BC_CHGR : BC_IDLE;
				end
			end
			BC_CHGR: begin
				if (msg_ready_in)
					next_bc_state = BC_IDLE;
			end
		endcase
	end

	assign msg_valid_out = (bc_state != BC_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// pulse control and switch outputs

	logic pulse_fet;
	logic chg_fet, next_chg_fet, dsg_fet, next_dsg_fet;

	bcc_pulse u_pulse (
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.sample_in   (tick),
		.active_in   (fc.pulse_mode && m.charging && !any_fault),
		.max_cell_in (m.max_cell),
		.von_in      (fc.pulse_von),
		.voff_in     (fc.pulse_voff),
		.vmax_in     (fc.pulse_vmax),
		.min_off_in  (fc.pulse_min_off),
		.max_on_in   (fc.pulse_max_on),
		.fet_on_out  (pulse_fet)
	);

	// faults override pulse; pulse off sets no fault
	always_comb begin
		next_chg_fet = !any_fault && (!fc.pulse_mode || pulse_fet);
		next_dsg_fet = !((fault.overcurrent && !fc.fixed_pack_bit)
			|| (fault.overtemp && fc.overtemp_fet_enable_bit));
		if (fault.overtemp && fc.overtemp_fet_enable_bit)
			next_chg_fet = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state registers

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			div_count <= 32'h0;
			fault     <= '0;
			oc_count  <= 8'h00;
			clr_count <= 8'h00;
			chg_time  <= 16'h0000;
			pre_volt  <= 1'b0;
			term_seen <= 1'b0;
			cur_req   <= 16'h0000;
			volt_req  <= 16'h0000;
			bc_state  <= BC_IDLE;
			bc_ticks  <= 8'h00;
			msg       <= '0;
			chg_fet   <= 1'b0;
			dsg_fet   <= 1'b1;
		end else begin
			div_count <= next_div_count;
			fault     <= next_fault;
			oc_count  <= next_oc_count;
			clr_count <= next_clr_count;
			chg_time  <= next_chg_time;
			pre_volt  <= next_pre_volt;
			term_seen <= next_term_seen;
			cur_req   <= next_current;
			volt_req  <= next_voltage;
			bc_state  <= next_bc_state;
			bc_ticks  <= next_bc_ticks;
			msg       <= next_msg;
			chg_fet   <= next_chg_fet;
			dsg_fet   <= next_dsg_fet;
		end
	end

	assign msg_out              = msg;
	assign charge_fet_out       = chg_fet;
	assign discharge_fet_out    = dsg_fet;
	assign fault_out            = fault;
	assign charging_current_out = cur_req;
	assign charging_voltage_out = volt_req;

endmodule

/* tb/battery_charge_control_tb_top.sv */
// testbench: charge requests, alarms, faults and pulse charge
`timescale 1ns/10ps
module battery_charge_control_tb_top;
	import bcc_pkg::*;
	localparam int unsigned SC = 10;
	logic                   clock_in = 1'b0;
	logic                   rst_in = 1'b1;
	logic                   slow = 1'b0;
	logic                   valid, ready, cfet, dfet;
	bcc_flash_constant_type fc;
	bcc_meas_type           ms;
	bcc_msg_type_s_type     msg;
	bcc_fault_type          flt;
	logic [15:0]            cur, vol, lc, lv, st;
	logic [15:0]            sv [4] = '{16'h1000, 16'h1000, 16'h0100, 16'h0000};
	int unsigned            nm, nr, n0, n1, cyc = 0, num_errors = 0, num_checks = 0;
	longint unsigned        rc, t0;

	// clock and hang guard
	always #10 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			test_done();
		end
	end

	bcc_top #(.SAMPLE_CNT(SC)) dut_u (.clock_in(clock_in), .rst_in(rst_in),
		.flash_constant_in(fc), .meas_in(ms), .msg_valid_out(valid), .msg_ready_in(ready),
		.msg_out(msg), .charge_fet_out(cfet), .discharge_fet_out(dfet), .fault_out(flt),
		.charging_current_out(cur), .charging_voltage_out(vol));
	bcc_chgr_model mdl_u (.clock_in(clock_in), .rst_in(rst_in), .slow_in(slow),
		.msg_valid_in(valid), .msg_in(msg), .msg_ready_out(ready), .last_current_out(lc),
		.last_voltage_out(lv), .msg_count_out(nm), .req_count_out(nr), .req_cycle_out(rc));

	////////////////////////////////////////////////////////////////////////////////
	// compares and helpers
	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t flag %b expected %b", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	// wait for the next charge request, then for its alarms
	task automatic burst;
		n0 = nr;
		for (int i = 0; i < 1000 && nr == n0; i++) @(negedge clock_in);
		chk1(nr != n0, 1'b1);
		wt(40);
	endtask
	task automatic req(input logic [15:0] t, m, input logic e, f, input logic [15:0] x);
		ms.temperature = t;
		ms.min_cell = m;
		ms.end_discharge_level_zero = e;
		ms.fast_terminated = f;
		wt(40);
		chk16(cur, x);
	endtask
	function automatic logic [15:0] exp_msgs(input logic [15:0] s);
		return 16'h0001 + 16'(|(s & HOST_ALARM_MASK)) + 16'(|(s & CHGR_ALARM_MASK));
	endfunction
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(54));
		fc = '{16'h3a98, 16'h01f4, 16'h0bb8, 16'h0064, 16'h00c8, 16'h0bb8, 16'h0064, 16'h0000,
			16'h01c2, 16'h0190, 16'h0032, 16'h1068, 16'h1004, 16'h0fa0, 8'h04, 16'h0032,
			8'h08, 16'hffff, 16'h0fd2, 16'h1018, 16'h1036, 8'h02, 8'h04, 8'h00, 1'b0, 1'b1, 1'b0};
		fc.fast_current = 16'($urandom_range(16'h0fff, 16'h0100));
		ms = '{16'h3000, 16'h0f00, 16'h0e00, 16'h00fa, 16'h07d0, 16'h07d0, 1'b1, 1'b0, 1'b0,
			1'b0, 1'b0, 16'h0000};
		wt(8);
		rst_in = 1'b0;
		burst();
		t0 = rc;
		burst();
		chk16(16'(rc - t0), 16'(80 * SC));
		chk16(lc, fc.fast_current);
		chk16(lv, fc.charging_voltage);
		chk16(vol, fc.charging_voltage);
		$display("test period done");
		for (int i = 0; i < 6; i++) begin
			st = (i < 4) ? sv[i] : 16'($urandom);
			ms.battery_status = st;
			slow = i[0];
			n1 = nm;
			burst();
			chk16(16'(nm - n1), exp_msgs(st));
		end
		ms.battery_status = 16'h0000;
		fc.pack_config = 8'h04;
		n1 = nm;
		wt(1700);
		chk16(16'(nm - n1), 16'h0000);
		fc.pack_config = 8'h00;
		$display("test broadcast done");
		req(16'h0081, 16'h0e00, 1'b0, 1'b0, fc.precharge_current);
		req(16'h0082, 16'h0e00, 1'b0, 1'b0, fc.fast_current);
		req(16'h00fa, 16'h0bb7, 1'b0, 1'b0, fc.precharge_current);
		req(16'h00fa, 16'h0bb9, 1'b1, 1'b0, fc.precharge_current);
		req(16'h00fa, 16'h0bb9, 1'b0, 1'b0, fc.fast_current);
		fc.precharge_temp_threshold = 16'h00c8;
		req(16'h00a0, 16'h0e00, 1'b0, 1'b0, fc.fast_current);
		fc.precharge_temp_threshold = 16'h0064;
		req(16'h00fa, 16'h0e00, 1'b0, 1'b1, 16'h0000);
		req(16'h00fa, 16'h0e00, 1'b0, 1'b0, fc.maint_current);
		$display("test request done");
		ms.charge_current = 16'h1388;
		wt(SC * 2);
		chk1(flt.overcurrent, 1'b0);
		wt(SC * 10);
		chk1(flt.overcurrent, 1'b1);
		chk1(dfet, 1'b0);
		chk16(cur, 16'h0000);
		chk16(vol, 16'h0000);
		ms.charge_current = 16'h07d0;
		wt(100);
		chk1(flt.overcurrent, 1'b1);
		ms.pack_removed = 1'b1;
		wt(20);
		chk1(flt.overcurrent, 1'b0);
		ms.max_cell = 16'h1100;
		wt(3);
		chk1(flt.overvoltage, 1'b1);
		chk1(cfet, 1'b0);
		ms.max_cell = 16'h1040;
		wt(20);
		chk1(flt.overvoltage, 1'b1);
		ms.max_cell = 16'h0f00;
		wt(20);
		chk1(flt.overvoltage, 1'b0);
		ms.pack_removed = 1'b0;
		ms.temperature = 16'h01c3;
		wt(10);
		chk1(dfet, 1'b0);
		ms.temperature = 16'h0190;
		wt(10);
		chk1(flt.overtemp, 1'b0);
		$display("test fault done");
		fc.pulse_mode = 1'b1;
		ms.max_cell = 16'h103c;
		wt(SC * 3);
		chk1(cfet, 1'b0);
		chk1(|flt, 1'b0);
		ms.max_cell = 16'h0f00;
		wt(SC * 5);
		chk1(cfet, 1'b1);
		ms.max_cell = 16'h1020;
		wt(SC * 3);
		chk1(cfet, 1'b1);
		wt(SC * 6);
		chk1(cfet, 1'b0);
		chk1(|flt, 1'b0);
		fc.pulse_mode = 1'b0;
		ms.max_cell = 16'h0f00;
		$display("test pulse done");
		fc.max_charge_time = 16'h0000;
		wt(3);
		chk1(flt.timeout, 1'b1);
		chk1(cfet, 1'b0);
		ms.charging = 1'b0;
		ms.discharging = 1'b1;
		wt(3);
		chk1(flt.timeout, 1'b0);
		fc.max_charge_time = 16'hffff;
		ms.charging = 1'b1;
		ms.discharging = 1'b0;
		ms.temperature = 16'h0031;
		wt(3);
		chk1(flt.undertemp, 1'b1);
		chk1(cfet, 1'b0);
		ms.temperature = 16'h0033;
		wt(3);
		chk1(flt.undertemp, 1'b0);
		$display("test timeout done");
		test_done();
	end
endmodule

/* tb/bcc_chgr_model.sv */
// partner: bus engine and smart charger taking each broadcast
`timescale 1ns/10ps
module bcc_chgr_model
	import bcc_pkg::*;
(
	// clock, reset and pace
	input  wire logic               clock_in,
	input  wire logic               rst_in,
	input  wire logic               slow_in,
	// message port
	input  wire logic               msg_valid_in,
	input  wire bcc_msg_type_s_type msg_in,
	output logic                    msg_ready_out,
	// applied values
	output logic [15:0]             last_current_out,
	output logic [15:0]             last_voltage_out,
	output int unsigned             msg_count_out,
	output int unsigned             req_count_out,
	output longint unsigned         req_cycle_out
);
	logic [3:0]      wait_q;
	longint unsigned cyc = 0;

	// ready for one cycle after a short or long wait
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (rst_in) begin
			msg_ready_out <= 1'b0;
			wait_q <= 4'h0;
			msg_count_out <= 0;
			req_count_out <= 0;
		end else if (msg_valid_in && msg_ready_out) begin
			msg_ready_out <= 1'b0;
			wait_q <= 4'h0;
			msg_count_out <= msg_count_out + 1;
			if (msg_in.kind == BCC_MSG_CHARGE_REQ) begin
				last_current_out <= msg_in.current;
				last_voltage_out <= msg_in.voltage;
				req_count_out <= req_count_out + 1;
				req_cycle_out <= cyc;
			end
		end else if (msg_valid_in) begin
			wait_q <= wait_q + 4'h1;
			msg_ready_out <= !slow_in || wait_q == 4'h6;
		end
	end
endmodule

/* tb/bcc_top_assertions.sv */
// checker: port-level properties of the charge control block
`timescale 1ns/10ps
module bcc_top_assertions
	import bcc_pkg::*;
#(
	parameter int unsigned SAMPLE_CNT = SAMPLE_CYCLES
)
(
	// clock and reset
	input wire logic                   clock_in,
	input wire logic                   rst_in,
	// settings and measurements
	input wire bcc_flash_constant_type flash_constant_in,
	input wire bcc_meas_type           meas_in,
	// message port
	input wire logic                   msg_valid_out,
	input wire logic                   msg_ready_in,
	input wire bcc_msg_type_s_type     msg_out,
	// switches and status
	input wire logic                   charge_fet_out,
	input wire logic                   discharge_fet_out,
	input wire bcc_fault_type          fault_out,
	input wire logic [15:0]            charging_current_out,
	input wire logic [15:0]            charging_voltage_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	////////////////////////////////////////////////////////////////////////////////
	// message handshake and burst order
	AST_MSG_HOLD: assert property (msg_valid_out && !msg_ready_in
		|=> msg_valid_out && $stable(msg_out))
		else $error("message changed before acceptance");
	AST_BURST_START: assert property ($rose(msg_valid_out)
		|-> msg_out.kind == BCC_MSG_CHARGE_REQ
		&& !flash_constant_in.pack_config[BCAST_DIS_POS])
		else $error("burst start wrong or not suppressed");
	AST_HOST_NEXT: assert property (msg_valid_out && msg_ready_in
		&& msg_out.kind == BCC_MSG_CHARGE_REQ
		|=> !msg_valid_out || msg_out.kind == BCC_MSG_ALARM_HOST)
		else $error("host alarm not after request");
	AST_HOST_BITS: assert property (msg_valid_out && msg_out.kind == BCC_MSG_ALARM_HOST
		|-> (msg_out.status & HOST_ALARM_MASK) != 16'h0000)
		else $error("host alarm without trigger bits");
	AST_CHGR_BITS: assert property (msg_valid_out
		&& msg_out.kind == BCC_MSG_ALARM_CHARGER
		|-> (msg_out.status & CHGR_ALARM_MASK) != 16'h0000)
		else $error("charger alarm without trigger bits");

	////////////////////////////////////////////////////////////////////////////////
	// faults and switches
	AST_FAULT_ZERO: assert property ((fault_out != 5'h00) [*3]
		|-> charging_current_out == 16'h0000 && charging_voltage_out == 16'h0000)
		else $error("nonzero request during fault");
	AST_FAULT_STOP: assert property ((fault_out.overcurrent || fault_out.undertemp
		|| fault_out.timeout || fault_out.overvoltage) [*3] |-> !charge_fet_out)
		else $error("charge switch on during fault");
	AST_OC_DSG: assert property ((fault_out.overcurrent
		&& !flash_constant_in.fixed_pack_bit) [*3] |-> !discharge_fet_out)
		else $error("discharge switch on during overcurrent");
	AST_OT_FETS: assert property ((fault_out.overtemp
		&& flash_constant_in.overtemp_fet_enable_bit) [*3]
		|-> !charge_fet_out && !discharge_fet_out)
		else $error("switches on during overtemperature");
	AST_CELL_OV: assert property (meas_in.max_cell > flash_constant_in.cell_ov_limit
		|=> fault_out.overvoltage)
		else $error("cell overvoltage not flagged");
	AST_OV_HOLD: assert property (fault_out.overvoltage
		&& meas_in.max_cell >= flash_constant_in.cell_ov_reset |=> fault_out.overvoltage)
		else $error("overvoltage released with high cell");

	// main scenarios
	cover property (msg_valid_out && msg_ready_in && msg_out.kind == BCC_MSG_ALARM_CHARGER);
	cover property ($rose(fault_out.overcurrent));
	cover property ($fell(charge_fet_out) && fault_out == 5'h00);
endmodule

bind bcc_top bcc_top_assertions #(.SAMPLE_CNT(SAMPLE_CNT)) chk_u (
	.clock_in(clock_in),
	.rst_in(rst_in),
	.flash_constant_in(flash_constant_in),
	.meas_in(meas_in),
	.msg_valid_out(msg_valid_out),
	.msg_ready_in(msg_ready_in),
	.msg_out(msg_out),
	.charge_fet_out(charge_fet_out),
	.discharge_fet_out(discharge_fet_out),
	.fault_out(fault_out),
	.charging_current_out(charging_current_out),
	.charging_voltage_out(charging_voltage_out)
);
